/* design/prs_map.svh */
// offsets, field positions, reset values and timing counts
// assumes a 40 MHz system clock and 32-bit apb data
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH

// clock rate in kHz
`define PRS_CLK_KHZ 64'd40000
// least time in us to whole cycles, rounded up
`define PRS_CYC(us) ((64'(us) * `PRS_CLK_KHZ + 64'd999) / 64'd1000)

// times in microseconds
`define PRS_T_RP_US 180000
`define PRS_T_DEG_US 192
`define PRS_T_SS_US 1500
`define PRS_T_GAP_US 1000
`define PRS_T_DCH_US 500
`define PRS_T_HIC_US 14000

// cycle counts derived from the times above
`define PRS_RP_CYC `PRS_CYC(`PRS_T_RP_US)
`define PRS_DEG_CYC `PRS_CYC(`PRS_T_DEG_US)
`define PRS_SPACE_CYC `PRS_CYC(`PRS_T_SS_US + `PRS_T_GAP_US)
`define PRS_DCH_CYC `PRS_CYC(`PRS_T_DCH_US)
`define PRS_HIC_CYC `PRS_CYC(`PRS_T_HIC_US)

// counter width, address width
`define PRS_CW 24
`define PRS_AW 8

// register byte offsets
`define PRS_OFF_CTRL 8'h00
`define PRS_OFF_STAT 8'h04
`define PRS_OFF_LIVE 8'h08

// control register: regulator bits 2:0, usb bits 4:3
`define PRS_CTRL_USB 3
`define PRS_CTRL_W 5

// status flag positions
`define PRS_ST_BROWN 0
`define PRS_ST_HOT 1
`define PRS_ST_LOCK 2
`define PRS_ST_USBF 3
`define PRS_ST_HIC 5
`define PRS_ST_W 8

// blanking lengths in switching cycles
`define PRS_BLANK_FIRST 5'h01
`define PRS_BLANK_MAX 5'h10

`endif

/* design/prs_pkg.sv */
// types for the power rail sequencer and supervisor
// assumes prs_map.svh is on the include path
package prs_pkg;
  `include "prs_map.svh"

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PRS_AW-1:0] paddr;
    logic [31:0] pwdata;
  } prs_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } prs_apb_rsp_t;

  // synchronous comparator results from the analog side
  typedef struct packed {
    logic monitor_a_low;
    logic monitor_b_low;
    logic main_lt_9p3;
    logic main_gt_10p8;
    logic main_lt_4p7;
    logic reg_in_lt_4p25;
    logic sw_in_lt_3p9;
    logic hot_warn;
  } prs_sense_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SPACE,
    SEQ_DISCH
  } prs_seq_t;

  // whole state of the block
  typedef struct packed {
    logic [31:0] rdata;
    logic [`PRS_CTRL_W-1:0] en_bits;
    logic [`PRS_ST_W-1:0] status;
    logic mon_flt;
    logic [`PRS_CW-1:0] deg_cnt;
    logic rst_hold;
    logic [`PRS_CW-1:0] rp_cnt;
    prs_seq_t seq;
    logic [`PRS_CW-1:0] seq_cnt;
    logic [2:0] reg_on;
    logic ss_dis;
    logic [2:0] hic;
    logic [2:0][`PRS_CW-1:0] hic_cnt;
    logic [2:0][4:0] blk_cnt;
    logic [2:0][4:0] blk_len;
    logic [1:0] usb_on;
    logic [1:0] usb_flt;
    logic brown;
    logic reg_in_lock;
    logic init;
    logic [`PRS_CW-1:0] init_cnt;
  } prs_st_t;

  localparam prs_st_t PRS_ST_RST = '{
    seq: SEQ_IDLE,
    rst_hold: 1'b1,
    init: 1'b1,
    blk_len: {3{`PRS_BLANK_FIRST}},
    default: '0
  };
endpackage : prs_pkg

/* design/prs_top.sv */
// power rail sequencer and supply supervisor, apb slave
// assumes comparator and pin levels are synchronous to clk_sys
//
// Contract
// - monitor dip gives reset of 180 ms
// - monitor inputs deglitched against brief dips
// - supervisor reset touches no rail or switch
// - usb switches follow pins, or bits serially
// - usb overload limits current, fault low
// - thermal warning turns usb off, auto restore in parallel mode
// - usb off while its supply invalid
// - grounded pin off, high pin starts at once
// - starts ordered, spaced soft-start plus 1 ms
// - enable pins discharged first at power-up
// - late enables follow default order
// - enable bits start rails, same arbitration
// - overcurrent blanks 1,2,4,8,16 switching cycles
// - shutdown waits fixed time, then retries
// - soft-start cap discharged between rails
// - warning low below 9.3, release above 10.8
// - warning also low while chip hot
// - separate flags; warning follows live levels
// - main below 9.3 usb off; 4.7 rails off
// - low rail or usb supply drops its group
// - lockout unlatched, enable pins held discharged
// - serial lockout clears bits, raises interrupt
// - faults flag, interrupt in serial mode only, read clears
module prs_top
  import prs_pkg::*;
#(
  parameter int unsigned RP_CYC = int'(`PRS_RP_CYC),
  parameter int unsigned DEG_CYC = int'(`PRS_DEG_CYC),
  parameter int unsigned SPACE_CYC = int'(`PRS_SPACE_CYC),
  parameter int unsigned DCH_CYC = int'(`PRS_DCH_CYC),
  parameter int unsigned HIC_CYC = int'(`PRS_HIC_CYC)
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire prs_apb_req_t apb_req,
  output prs_apb_rsp_t apb_rsp,
  input wire prs_sense_t sense,
  input wire logic serial_mode,
  input wire logic [2:0] regulator_enable_pin,
  input wire logic [1:0] usb_enable_pin,
  input wire logic [1:0] usb_overload,
  input wire logic [2:0] sw_tick,
  input wire logic [2:0] buck_oc,
  input wire logic [2:0] buck_out_uv,
  output logic supervisor_rst_n,
  output logic early_warning_out_n,
  output logic irq,
  output logic [2:0] reg_on,
  output logic [2:0] high_side_en,
  output logic ss_discharge,
  output logic enable_pin_discharge,
  output logic [1:0] usb_switch_on,
  output logic [1:0] usb_current_limit,
  output logic [1:0] usb_switch_fault_out_n
);
  localparam int CW = `PRS_CW;

  prs_st_t r;
  prs_st_t n;
  logic mon_raw;
  logic buck_lock;
  logic usb_block;
  logic [1:0] usb_req;
  logic [2:0] want;
  logic [2:0] pick;
  logic setup_ph;
  logic access_ph;
  logic [31:0] rd_val;

  // comparator groups and lockout conditions
  assign mon_raw = sense.monitor_a_low | sense.monitor_b_low;
  assign buck_lock = sense.main_lt_4p7 | r.reg_in_lock | r.init;
  assign usb_block = sense.main_lt_9p3 | sense.sw_in_lt_3p9
    | sense.hot_warn | sense.main_lt_4p7;

  // switch request: pin in parallel mode, bit in serial mode
  assign usb_req = serial_mode
    ? r.en_bits[`PRS_CTRL_USB +: 2] : usb_enable_pin;

  // regulator request: pin always, bit too in serial mode
  assign want = (regulator_enable_pin
    | (serial_mode ? r.en_bits[2:0] : 3'h0))
    & ~r.hic & {3{~buck_lock}};

  // lowest pending rail wins, giving order one, two, three
  always_comb begin
    pick = 3'h0;
    if (want[0] && !r.reg_on[0]) begin
      pick = 3'h1;
    end else if (want[1] && !r.reg_on[1]) begin
      pick = 3'h2;
    end else if (want[2] && !r.reg_on[2]) begin
      pick = 3'h4;
    end
  end

  // apb phases and read mux
  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign access_ph = apb_req.psel & apb_req.penable;
  always_comb begin
    rd_val = 32'h0;
    unique case (apb_req.paddr)
      `PRS_OFF_CTRL: rd_val[`PRS_CTRL_W-1:0] = r.en_bits;
      `PRS_OFF_STAT: rd_val[`PRS_ST_W-1:0] = r.status;
      `PRS_OFF_LIVE: rd_val[12:0] = {serial_mode, 1'b0, r.usb_flt,
        r.usb_on, r.hic, r.reg_on, r.rst_hold};
      default: rd_val = 32'h0;
    endcase
  end

  // next state of the whole block
  always_comb begin
    n = r;
    if (ce) begin
      // deglitch the combined monitor level, both edges
      if (mon_raw == r.mon_flt) begin
        n.deg_cnt = '0;
      end else if (r.deg_cnt == CW'(DEG_CYC - 1)) begin
        n.mon_flt = mon_raw;
        n.deg_cnt = '0;
      end else begin
        n.deg_cnt = r.deg_cnt + CW'(1);
      end

      // reset pulse, restarted by every dip
      if (r.mon_flt) begin
        n.rst_hold = 1'b1;
        n.rp_cnt = '0;
      end else if (r.rst_hold) begin
        if (r.rp_cnt == CW'(RP_CYC - 1)) begin
          n.rst_hold = 1'b0;
        end else begin
          n.rp_cnt = r.rp_cnt + CW'(1);
        end
      end

      // power-up discharge of the enable pins
      if (r.init) begin
        if (r.init_cnt == CW'(DCH_CYC - 1)) begin
          n.init = 1'b0;
        end else begin
          n.init_cnt = r.init_cnt + CW'(1);
        end
      end

      // brownout with hysteresis
      if (sense.main_lt_9p3) begin
        n.brown = 1'b1;
      end else if (sense.main_gt_10p8) begin
        n.brown = 1'b0;
      end

      // regulator-supply lockout holds until recovery
      if (sense.reg_in_lt_4p25 && (r.reg_on[1] || r.reg_on[2])) begin
        n.reg_in_lock = 1'b1;
      end else if (!sense.reg_in_lt_4p25) begin
        n.reg_in_lock = 1'b0;
      end

      // rails drop as soon as their request goes
      n.reg_on = r.reg_on & want;

      // hiccup: output collapse shuts rail, wait, retry
      for (int i = 0; i < 3; i++) begin
        if (r.hic[i]) begin
          if (r.hic_cnt[i] == CW'(HIC_CYC - 1)) begin
            n.hic[i] = 1'b0;
            n.hic_cnt[i] = '0;
          end else begin
            n.hic_cnt[i] = r.hic_cnt[i] + CW'(1);
          end
        end else if (r.reg_on[i] && buck_out_uv[i]) begin
          n.hic[i] = 1'b1;
          n.reg_on[i] = 1'b0;
        end
      end

      // cycle-by-cycle blanking per rail
      for (int i = 0; i < 3; i++) begin
        if (!r.reg_on[i]) begin
          n.blk_cnt[i] = '0;
          n.blk_len[i] = `PRS_BLANK_FIRST;
        end else if (sw_tick[i]) begin
          if (r.blk_cnt[i] != 5'h0) begin
            n.blk_cnt[i] = r.blk_cnt[i] - 5'h1;
          end else if (buck_oc[i]) begin
            n.blk_cnt[i] = r.blk_len[i];
            n.blk_len[i] = (r.blk_len[i] >= (`PRS_BLANK_MAX >> 1))
              ? `PRS_BLANK_MAX : {r.blk_len[i][3:0], 1'b0};
          end else begin
            n.blk_len[i] = `PRS_BLANK_FIRST;
          end
        end
      end

      // start sequencer: start, hold spacing, discharge cap
      unique case (r.seq)
        SEQ_IDLE: begin
          if (pick != 3'h0) begin
            n.reg_on = n.reg_on | pick;
            n.seq = SEQ_SPACE;
            n.seq_cnt = '0;
          end
        end
        SEQ_SPACE: begin
          if (r.seq_cnt == CW'(SPACE_CYC - 1)) begin
            n.seq = SEQ_DISCH;
            n.seq_cnt = '0;
            n.ss_dis = 1'b1;
          end else begin
            n.seq_cnt = r.seq_cnt + CW'(1);
          end
        end
        SEQ_DISCH: begin
          if (r.seq_cnt == CW'(DCH_CYC - 1)) begin
            n.seq = SEQ_IDLE;
            n.ss_dis = 1'b0;
            n.seq_cnt = '0;
          end else begin
            n.seq_cnt = r.seq_cnt + CW'(1);
          end
        end
      endcase

      // usb switches and their overload flags
      n.usb_on = usb_req & {2{~usb_block}};
      n.usb_flt = n.usb_on & usb_overload;

      // apb read data captured at setup, write at access
      if (setup_ph) begin
        n.rdata = rd_val;
      end
      if (access_ph && apb_req.pwrite
          && apb_req.paddr == `PRS_OFF_CTRL) begin
        n.en_bits = apb_req.pwdata[`PRS_CTRL_W-1:0];
      end

      // read clears only the flags that were returned
      if (access_ph && !apb_req.pwrite
          && apb_req.paddr == `PRS_OFF_STAT) begin
        n.status = r.status & ~r.rdata[`PRS_ST_W-1:0];
      end

      // lockout in serial mode clears the enable bits
      if (serial_mode && (buck_lock || usb_block)) begin
        n.en_bits = '0;
      end

      // set wins over clear for every flag
      n.status[`PRS_ST_BROWN] = n.status[`PRS_ST_BROWN]
        | sense.main_lt_9p3;
      n.status[`PRS_ST_HOT] = n.status[`PRS_ST_HOT]
        | sense.hot_warn;
      n.status[`PRS_ST_LOCK] = n.status[`PRS_ST_LOCK]
        | sense.main_lt_4p7 | r.reg_in_lock
        | sense.sw_in_lt_3p9;
      n.status[`PRS_ST_USBF +: 2] = n.status[`PRS_ST_USBF +: 2]
        | r.usb_flt;
      n.status[`PRS_ST_HIC +: 3] = n.status[`PRS_ST_HIC +: 3]
        | r.hic;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= PRS_ST_RST;
    end else begin
      r <= n;
    end
  end

  // outputs from state, warning, pin discharge and irq also from live inputs; reset drives nothing else
  assign supervisor_rst_n = ~r.rst_hold;
  assign early_warning_out_n = ~(r.brown | sense.hot_warn);
  assign irq = serial_mode & (|r.status);
  assign reg_on = r.reg_on;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      high_side_en[i] = r.reg_on[i] & (r.blk_cnt[i] == 5'h0);
    end
  end
  assign ss_discharge = r.ss_dis;
  assign enable_pin_discharge = buck_lock;
  assign usb_switch_on = r.usb_on;
  assign usb_current_limit = r.usb_flt;
  assign usb_switch_fault_out_n = ~r.usb_flt;

  // apb answer: no wait states, unmapped address flagged
  always_comb begin
    apb_rsp.prdata = r.rdata;
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = access_ph
      && apb_req.paddr != `PRS_OFF_CTRL
      && apb_req.paddr != `PRS_OFF_STAT
      && apb_req.paddr != `PRS_OFF_LIVE;
  end

  // helper counters watched by the checks below
  logic [CW-1:0] low_len;
  logic [CW-1:0] gap;
  logic [2:0] new_on;
  assign new_on = n.reg_on & ~r.reg_on; // rails starting this cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_len <= '0;
      gap <= CW'(SPACE_CYC);
    end else if (ce) begin
      low_len <= r.rst_hold ? low_len + CW'(1) : '0;
      if (new_on != 3'h0) begin
        gap <= '0;
      end else if (gap != CW'(SPACE_CYC)) begin
        gap <= gap + CW'(1);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_length: assert property (
    $rose(supervisor_rst_n) |-> $past(low_len) >= CW'(RP_CYC - 1))
    else $error("reset pulse too short");
  a_dip_filtered: assert property (
    (ce && !r.mon_flt && !mon_raw ##1 mon_raw) |=> !r.mon_flt)
    else $error("brief dip passed the filter");
  a_usb_follow: assert property (
    (ce && !usb_block) |=> usb_switch_on == $past(usb_req))
    else $error("usb switch ignores its enable");
  a_usb_fault: assert property (
    (ce && usb_req[0] && usb_overload[0] && !usb_block)
      |=> !usb_switch_fault_out_n[0])
    else $error("usb fault not flagged");
  a_usb_blocked: assert property (
    (ce && (sense.hot_warn || sense.sw_in_lt_3p9)) |=> usb_switch_on == 2'h0)
    else $error("usb on while blocked");
  a_start_spacing: assert property (
    (ce && new_on != 3'h0)
      |-> gap == CW'(SPACE_CYC) && $onehot(new_on))
    else $error("rail starts too close");
  a_ocp_blank: assert property (
    (ce && reg_on[0] && sw_tick[0] && buck_oc[0] && r.blk_cnt[0] == 5'h0)
      |=> !high_side_en[0] && r.blk_cnt[0] == $past(r.blk_len[0]))
    else $error("overcurrent cycle not blanked");
  a_brownout_warn: assert property (
    (ce && sense.main_lt_9p3) |=> !early_warning_out_n [*1])
    else $error("brownout warning missing");
  a_main_lockout: assert property (
    (ce && sense.main_lt_4p7) |=> reg_on == 3'h0 && usb_switch_on == 2'h0)
    else $error("rails on during lockout");
  a_lock_clears: assert property (
    (ce && serial_mode && sense.main_lt_4p7)
      |=> r.en_bits == '0 ##0 irq)
    else $error("lockout kept enable bits");
  a_hiccup_off: assert property (
    (ce && reg_on[0] && buck_out_uv[0]) |=> !reg_on[0] && r.hic[0])
    else $error("rail kept running after collapse");
  a_warn_release: assert property (
    (ce && sense.main_gt_10p8 && !sense.main_lt_9p3 && !sense.hot_warn)
      |=> !r.brown)
    else $error("brownout warning held after recovery");
  a_cap_discharge: assert property (
    (ce && r.seq == SEQ_SPACE && r.seq_cnt == CW'(SPACE_CYC - 1))
      |=> ss_discharge && new_on == 3'h0)
    else $error("soft-start cap not discharged");
endmodule : prs_top

/* bench/prs_host_model.sv */
// host side model: watches the reset output
// assumes outputs are synchronous to clk_sys
module prs_host_model (
  input wire logic clk_sys,
  input wire logic supervisor_rst_n,
  output logic [31:0] pulse_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] run = '0;
  initial pulse_len = '0;
  // length in cycles of the last finished reset pulse
  always @(posedge clk_sys) begin
    if (supervisor_rst_n === 1'b0) begin
      run <= run + 32'h1;
    end else if (run != 32'h0) begin
      pulse_len <= run;
      run <= '0;
    end
  end
endmodule : prs_host_model

/* bench/prs_top_tb_top.sv */
// self-checking bench for the rail sequencer and supervisor
// assumes short count parameters and a zero wait apb slave
module prs_top_tb_top
  import prs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RP = 50;
  localparam int SP = 20;
  localparam int HC = 10;
  logic clk_sys, rst, serial_mode;
  prs_apb_req_t req;
  prs_apb_rsp_t rsp;
  prs_sense_t sense;
  logic [2:0] pins, reg_on, hs_en;
  logic [2:0] tick, boc, buv;
  logic [1:0] upin, uovl, usb_on, ulim, ufault_n;
  logic sup_rst_n, warn_n, irq, ss_discharge, pin_dis;
  logic [31:0] plen, q;
  logic e;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;

  prs_top #(.RP_CYC(RP), .DEG_CYC(4), .SPACE_CYC(SP), .DCH_CYC(5),
    .HIC_CYC(HC)) DUT (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .apb_req(req),
    .apb_rsp(rsp), .sense(sense), .serial_mode(serial_mode),
    .regulator_enable_pin(pins), .usb_enable_pin(upin),
    .usb_overload(uovl), .sw_tick(tick), .buck_oc(boc),
    .buck_out_uv(buv), .supervisor_rst_n(sup_rst_n),
    .early_warning_out_n(warn_n), .irq(irq), .reg_on(reg_on),
    .high_side_en(hs_en), .ss_discharge(ss_discharge),
    .enable_pin_discharge(pin_dis), .usb_switch_on(usb_on),
    .usb_current_limit(ulim), .usb_switch_fault_out_n(ufault_n));

  prs_host_model host (.clk_sys(clk_sys), .supervisor_rst_n(sup_rst_n),
    .pulse_len(plen));

  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic chk_ge(input string nm, input int x, input int g);
    checked++;
    if (!(g >= x)) begin
      fail_count++;
      $display("Error %s expected at least %0d seen %0d", nm, x, g);
    end
  endtask : chk_ge

  task automatic nc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : nc

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    @(posedge clk_sys);
    while (rsp.pready !== 1'b1) @(posedge clk_sys);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // cycles until rail b runs, noting any soft-start discharge
  task automatic wait_on(input int b, output int n, output logic ss);
    n = 0;
    ss = 1'b0;
    while (reg_on[b] !== 1'b1 && n < 500) begin
      @(negedge clk_sys);
      n++;
      if (ss_discharge === 1'b1) ss = 1'b1;
    end
  endtask : wait_on

  task automatic t_reset;
    @(negedge clk_sys);
    chk("rst_n", 0, sup_rst_n);
    chk("pin_dis", 1, pin_dis);
    nc(RP + 20);
    chk("rst_n", 1, sup_rst_n);
    chk_ge("pulse", RP, plen);
    chk("pin_dis", 0, pin_dis);
    $display("test reset done");
  endtask : t_reset

  task automatic t_seq;
    int n;
    logic ss;
    @(posedge clk_sys);
    pins <= 3'b111;
    nc(2);
    chk("reg_on", 3'b001, reg_on);
    wait_on(1, n, ss);
    chk_ge("gap1", SP, n);
    chk("ss1", 1, ss);
    chk("reg_on", 3'b011, reg_on);
    wait_on(2, n, ss);
    chk_ge("gap2", SP, n);
    chk("ss2", 1, ss);
    $display("test sequence done");
  endtask : t_seq

  // one switching tick on rail one, with or without overcurrent
  task automatic pulse_tick(input logic [2:0] oc);
    @(posedge clk_sys);
    tick <= 3'b001;
    boc <= oc;
    @(posedge clk_sys);
    tick <= 3'b000;
    boc <= 3'b000;
    @(negedge clk_sys);
  endtask : pulse_tick

  task automatic t_ocp;
    int n;
    logic ss;
    logic [4:0] len;
    len = 5'h01;
    for (int k = 0; k < 6; k++) begin
      pulse_tick(3'b001);
      chk("hs_blank", 0, hs_en[0]);
      n = 0;
      while (hs_en[0] !== 1'b1 && n < 40) begin
        pulse_tick(3'b000);
        n++;
      end
      chk("blank_len", len, n);
      len = (len == 5'h10) ? len : len << 1;
    end
    pulse_tick(3'b000);
    pulse_tick(3'b001);
    pulse_tick(3'b000);
    chk("blank_reset", 1, hs_en[0]);
    @(posedge clk_sys);
    buv <= 3'b001;
    @(posedge clk_sys);
    buv <= 3'b000;
    @(negedge clk_sys);
    chk("hic_off", 3'b110, reg_on);
    wait_on(0, n, ss);
    chk_ge("hic_wait", HC, n);
    chk("hic_retry", 3'b111, reg_on);
    $display("test overcurrent done");
  endtask : t_ocp

  task automatic t_mon;
    @(posedge clk_sys);
    sense.monitor_a_low <= 1'b1;
    @(posedge clk_sys);
    sense.monitor_a_low <= 1'b0;
    nc(10);
    chk("glitch", 1, sup_rst_n);
    @(posedge clk_sys);
    sense.monitor_b_low <= 1'b1;
    nc(10);
    chk("dip", 0, sup_rst_n);
    chk("rails", 3'b111, reg_on);
    @(posedge clk_sys);
    sense.monitor_b_low <= 1'b0;
    nc(20);
    @(posedge clk_sys);
    sense.monitor_a_low <= 1'b1;
    nc(8);
    @(posedge clk_sys);
    sense.monitor_a_low <= 1'b0;
    nc(RP + 20);
    chk("rst_n", 1, sup_rst_n);
    chk_ge("redip", RP + 28, plen);
    $display("test supervisor done");
  endtask : t_mon

  task automatic t_usb;
    @(posedge clk_sys);
    upin <= 2'b01;
    uovl <= 2'b01;
    nc(3);
    chk("usb", 2'b01, usb_on);
    chk("fault_n", 2'b10, ufault_n);
    chk("limit", 2'b01, ulim);
    @(posedge clk_sys);
    uovl <= 2'b00;
    sense.hot_warn <= 1'b1;
    nc(3);
    chk("usb_hot", 2'b00, usb_on);
    chk("warn_hot", 0, warn_n);
    @(posedge clk_sys);
    sense.hot_warn <= 1'b0;
    sense.sw_in_lt_3p9 <= 1'b1;
    nc(3);
    chk("warn_cool", 1, warn_n);
    chk("usb_supply", 2'b00, usb_on);
    @(posedge clk_sys);
    sense.sw_in_lt_3p9 <= 1'b0;
    nc(3);
    chk("usb_back", 2'b01, usb_on);
    @(posedge clk_sys);
    serial_mode <= 1'b1;
    apb(1'b1, 8'h00, 32'h00000010);
    nc(3);
    chk("usb_bits", 2'b10, usb_on);
    $display("test usb done");
  endtask : t_usb

  task automatic t_brown;
    @(posedge clk_sys);
    sense.main_gt_10p8 <= 1'b0;
    sense.main_lt_9p3 <= 1'b1;
    nc(3);
    chk("warn", 0, warn_n);
    chk("usb_off", 2'b00, usb_on);
    chk("irq", 1, irq);
    @(posedge clk_sys);
    sense.main_lt_9p3 <= 1'b0;
    nc(3);
    apb(1'b0, 8'h04, '0);
    chk("st_brown", 1, q[0]);
    chk("st_hot", 1, q[1]);
    nc(1);
    chk("warn_hyst", 0, warn_n);
    @(posedge clk_sys);
    sense.main_gt_10p8 <= 1'b1;
    nc(3);
    chk("warn_rel", 1, warn_n);
    apb(1'b0, 8'h0c, '0);
    chk("slverr", 1, e);
    chk("unmapped", 0, q);
    $display("test brownout done");
  endtask : t_brown

  task automatic t_lock;
    int n;
    logic ss;
    @(posedge clk_sys);
    pins <= 3'b000;
    apb(1'b1, 8'h00, 32'h0000001f);
    @(posedge clk_sys);
    sense.main_lt_4p7 <= 1'b1;
    sense.main_lt_9p3 <= 1'b1;
    nc(3);
    chk("rails_off", 3'b000, reg_on);
    chk("pin_dis", 1, pin_dis);
    chk("irq", 1, irq);
    apb(1'b0, 8'h00, '0);
    chk("ctrl_clr", 0, q);
    @(posedge clk_sys);
    sense.main_lt_4p7 <= 1'b0;
    sense.main_lt_9p3 <= 1'b0;
    nc(3);
    chk("pin_rel", 0, pin_dis);
    apb(1'b1, 8'h00, 32'h00000001);
    wait_on(0, n, ss);
    chk("rail_bit", 3'b001, reg_on);
    @(posedge clk_sys);
    sense.reg_in_lt_4p25 <= 1'b1;
    nc(3);
    chk("rail1_only", 3'b001, reg_on);
    apb(1'b1, 8'h00, 32'h00000003);
    wait_on(1, n, ss);
    nc(2);
    chk("rails_drop", 3'b000, reg_on);
    @(posedge clk_sys);
    sense.reg_in_lt_4p25 <= 1'b0;
    nc(3);
    chk("lock_rel", 0, pin_dis);
    apb(1'b0, 8'h04, '0);
    apb(1'b0, 8'h04, '0);
    nc(1);
    chk("irq_clr", 0, irq);
    $display("test lockout done");
  endtask : t_lock

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    rst = 1'b1;
    serial_mode = 1'b0;
    req = '0;
    sense = '0;
    sense.main_gt_10p8 = 1'b1;
    pins = '0;
    upin = '0;
    uovl = '0;
    tick = '0;
    boc = '0;
    buv = '0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_seq();
    t_ocp();
    t_mon();
    t_usb();
    t_brown();
    t_lock();
    end_sim();
  end
endmodule : prs_top_tb_top
